// file: core/adcctl_top.sv
// Converter control and configuration block with an Avalon-MM slave.
//
// The Avalon-MM slave port was chosen for this implementation.
`timescale 1ns/1ps
module adcctl_top
	import adcctl_pkg::*;
#(
	parameter bit SMALL_PACKAGE = 1'b0
) (
	input  wire logic            sys_clk,
	input  wire logic            nrst,
	input  wire adcctl_bus_req_t avs_req,
	output adcctl_bus_rsp_t      avs_rsp,
	input  wire logic            rc_clk_in,
	input  wire logic [9:0]      conv_sample,
	output logic                 converter_power_on,
	output logic [2:0]           input_channel_sel,
	output logic                 sample_enable,
	output logic                 conv_bit_tick,
	output adcctl_pins_t         pin_cfg,
	output logic                 irq
);

	adcctl_regs_t r_reg;
	adcctl_regs_t r_next;
	logic         wr_hit;
	logic         rd_hit;
	logic         rc_edge;
	logic [5:0]   div_max;
	logic         start_req;
	logic         abort;
	logic [7:0]   an_raw;

	assign wr_hit = avs_req.write && r_reg.ack_reg;
	assign rd_hit = avs_req.read && !r_reg.ack_reg;
	assign avs_rsp.waitrequest = (avs_req.read || avs_req.write) && !r_reg.ack_reg;
	assign avs_rsp.readdata = r_reg.readdata_reg;

	always_comb begin
		case (r_reg.control_reg[CTL_CLK_POS +: 2])
			2'b00:   div_max = DIV_FOSC2;
			2'b01:   div_max = DIV_FOSC8;
			2'b10:   div_max = DIV_FOSC32;
			default: div_max = DIV_FOSC2;
		endcase
	end
	assign rc_edge = r_reg.rc_sync_reg[1] == r_reg.rc_sync_reg[2] && r_reg.rc_sync_reg[2]
		&& !r_reg.rc_level_reg;

	assign start_req = wr_hit && avs_req.address == ADDR_CONTROL
		&& avs_req.writedata[CTL_START_POS] && r_reg.control_reg[CTL_PWR_POS];
	assign abort = wr_hit && avs_req.address == ADDR_CONTROL
		&& !avs_req.writedata[CTL_START_POS] && r_reg.state_reg == ADCCTL_CONV;

	always_comb begin
		an_raw = 8'h00;
		pin_cfg.vref_pos_sel = 2'h0;
		pin_cfg.vref_neg_sel = 2'h0;
		case (r_reg.config_reg[3:0])
			4'h0: an_raw = 8'hff;
			4'h1: an_raw = 8'hf7;
			4'h2: an_raw = 8'h1f;
			4'h3: an_raw = 8'h17;
			4'h4: an_raw = 8'h0b;
			4'h5: an_raw = 8'h03;
			4'h8: an_raw = 8'hf3;
			4'h9: an_raw = 8'h3f;
			4'ha: an_raw = 8'h37;
			4'hb: an_raw = 8'h33;
			4'hc: an_raw = 8'h13;
			4'hd: an_raw = 8'h03;
			4'he: an_raw = 8'h01;
			4'hf: an_raw = 8'h01;
			default: an_raw = 8'h00;
		endcase
		case (r_reg.config_reg[3:0])
			4'h1, 4'h3, 4'h5, 4'ha: pin_cfg.vref_pos_sel = 2'h1;
			4'h8, 4'hb, 4'hc, 4'hd, 4'hf: begin
				pin_cfg.vref_pos_sel = 2'h1;
				pin_cfg.vref_neg_sel = 2'h1;
			end
			default: pin_cfg.vref_pos_sel = 2'h0;
		endcase
		pin_cfg.analog_en = SMALL_PACKAGE ? (an_raw & 8'h1f) : an_raw;
	end

	always_comb begin
		r_next = r_reg;
		r_next.ack_reg = 1'b0;
		r_next.tick_reg = 1'b0;
		r_next.rc_sync_reg = {r_reg.rc_sync_reg[1:0], rc_clk_in};
		if (r_reg.rc_sync_reg[1] == r_reg.rc_sync_reg[2]) begin
			r_next.rc_level_reg = r_reg.rc_sync_reg[2];
		end
		if (r_reg.control_reg[CTL_CLK_POS +: 2] == 2'b11) begin
			r_next.tick_reg = rc_edge;
		end else if (r_reg.div_cnt_reg >= div_max - 6'h01) begin
			r_next.div_cnt_reg = 6'h00;
			r_next.tick_reg = 1'b1;
		end else begin
			r_next.div_cnt_reg = r_reg.div_cnt_reg + 6'h01;
		end
		if ((avs_req.read || avs_req.write) && !r_reg.ack_reg) begin
			r_next.ack_reg = 1'b1;
		end
		if (rd_hit) begin
			case (avs_req.address)
				ADDR_CONTROL: r_next.readdata_reg = r_reg.control_reg;
				ADDR_CONFIG:  r_next.readdata_reg = r_reg.config_reg & CONFIG_MASK;
				ADDR_RES_HI:  r_next.readdata_reg = r_reg.config_reg[CFG_FMT_POS]
					? {6'h00, r_reg.result_reg[9:8]} : r_reg.result_reg[9:2];
				ADDR_RES_LO:  r_next.readdata_reg = r_reg.config_reg[CFG_FMT_POS]
					? r_reg.result_reg[7:0] : {r_reg.result_reg[1:0], 6'h00};
				ADDR_STATUS:  r_next.readdata_reg = {7'h00, r_reg.done_flag_reg};
				ADDR_MASK:    r_next.readdata_reg = {7'h00, r_reg.done_mask_reg};
				default:      r_next.readdata_reg = 8'h00;
			endcase
		end
		if (wr_hit) begin
			case (avs_req.address)
				ADDR_CONTROL: begin
					r_next.control_reg = avs_req.writedata;
					r_next.control_reg[1] = 1'b0;
					r_next.control_reg[CTL_START_POS] = start_req
						|| (avs_req.writedata[CTL_START_POS] && r_reg.control_reg[CTL_START_POS]);
					if (SMALL_PACKAGE && avs_req.writedata[CTL_CHAN_POS +: 3] > 3'h4) begin
						r_next.control_reg[CTL_CHAN_POS +: 3] = r_reg.control_reg[CTL_CHAN_POS +: 3];
					end
				end
				ADDR_CONFIG:  r_next.config_reg = avs_req.writedata & CONFIG_MASK;
				ADDR_RES_HI:  r_next.result_reg = r_reg.config_reg[CFG_FMT_POS]
					? {avs_req.writedata[1:0], r_reg.result_reg[7:0]}
					: {avs_req.writedata, r_reg.result_reg[1:0]};
				ADDR_RES_LO:  r_next.result_reg = r_reg.config_reg[CFG_FMT_POS]
					? {r_reg.result_reg[9:8], avs_req.writedata}
					: {r_reg.result_reg[9:2], avs_req.writedata[7:6]};
				ADDR_STATUS:  if (avs_req.writedata[0]) r_next.done_flag_reg = 1'b0;
				ADDR_MASK:    r_next.done_mask_reg = avs_req.writedata[0];
				default:      begin end
			endcase
		end
		case (r_reg.state_reg)
			ADCCTL_OFF: begin
				if (r_reg.control_reg[CTL_PWR_POS]) begin
					r_next.state_reg = ADCCTL_ACQ;
				end
			end
			ADCCTL_ACQ: begin
				if (r_reg.control_reg[CTL_START_POS]) begin
					r_next.state_reg = ADCCTL_CONV;
					r_next.per_cnt_reg = 4'h0;
				end
			end
			ADCCTL_CONV: begin
				if (abort) begin
					r_next.state_reg = ADCCTL_WAIT;
					r_next.per_cnt_reg = 4'h0;
				end else if (r_reg.tick_reg) begin
					if (r_reg.per_cnt_reg == CONV_PERIODS - 4'h1) begin
						r_next.result_reg = conv_sample;
						r_next.done_flag_reg = 1'b1;
						r_next.control_reg[CTL_START_POS] = 1'b0;
						r_next.state_reg = ADCCTL_WAIT;
						r_next.per_cnt_reg = 4'h0;
					end else begin
						r_next.per_cnt_reg = r_reg.per_cnt_reg + 4'h1;
					end
				end
			end
			ADCCTL_WAIT: begin
				if (r_reg.tick_reg) begin
					if (r_reg.per_cnt_reg == WAIT_PERIODS - 4'h1) begin
						r_next.state_reg = ADCCTL_ACQ;
					end else begin
						r_next.per_cnt_reg = r_reg.per_cnt_reg + 4'h1;
					end
				end
			end
			default: r_next.state_reg = ADCCTL_OFF;
		endcase
		if (!r_next.control_reg[CTL_PWR_POS]) begin
			r_next.state_reg = ADCCTL_OFF;
			r_next.control_reg[CTL_START_POS] = 1'b0;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			r_reg <= '{control_reg: CONTROL_RESET, config_reg: CONFIG_RESET,
				state_reg: ADCCTL_OFF, default: '0};
		end else begin
			r_reg <= r_next;
		end
	end

	assign converter_power_on = r_reg.control_reg[CTL_PWR_POS];
	assign input_channel_sel = r_reg.control_reg[CTL_CHAN_POS +: 3];
	assign sample_enable = r_reg.state_reg == ADCCTL_ACQ;
	assign conv_bit_tick = r_reg.tick_reg;
	assign irq = r_reg.done_flag_reg && r_reg.done_mask_reg;

	property p_done_clears_start;
		@(posedge sys_clk) disable iff (!nrst)
		$rose(r_reg.done_flag_reg) |-> !r_reg.control_reg[CTL_START_POS];
	endproperty
	a_done_clears_start: assert property (p_done_clears_start)
		else $error("start bit still set after completion");

	property p_start_needs_power;
		@(posedge sys_clk) disable iff (!nrst)
		$rose(r_reg.control_reg[CTL_START_POS]) |-> $past(r_reg.control_reg[CTL_PWR_POS]);
	endproperty
	a_start_needs_power: assert property (p_start_needs_power)
		else $error("conversion started while unpowered");

	property p_cfg_zero_bits;
		@(posedge sys_clk) disable iff (!nrst)
		(avs_req.read && avs_req.address == ADDR_CONFIG && !avs_rsp.waitrequest)
			|-> avs_rsp.readdata[6:4] == 3'h0;
	endproperty
	a_cfg_zero_bits: assert property (p_cfg_zero_bits)
		else $error("unimplemented config bits read nonzero");

	property p_right_just;
		@(posedge sys_clk) disable iff (!nrst)
		(avs_req.read && avs_req.address == ADDR_RES_HI && !avs_rsp.waitrequest
			&& r_reg.config_reg[CFG_FMT_POS]) |-> avs_rsp.readdata[7:2] == 6'h00;
	endproperty
	a_right_just: assert property (p_right_just)
		else $error("high byte upper bits nonzero");

	property p_left_just;
		@(posedge sys_clk) disable iff (!nrst)
		(avs_req.read && avs_req.address == ADDR_RES_LO && !avs_rsp.waitrequest
			&& !r_reg.config_reg[CFG_FMT_POS]) |-> avs_rsp.readdata[5:0] == 6'h00;
	endproperty
	a_left_just: assert property (p_left_just)
		else $error("low byte lower bits nonzero");

	property p_abort_keeps_result;
		@(posedge sys_clk) disable iff (!nrst)
		abort && avs_req.writedata[CTL_PWR_POS]
			|=> $stable(r_reg.result_reg) && r_reg.state_reg == ADCCTL_WAIT;
	endproperty
	a_abort_keeps_result: assert property (p_abort_keeps_result)
		else $error("abort changed result");

	property p_off_when_unpowered;
		@(posedge sys_clk) disable iff (!nrst)
		!converter_power_on |-> r_reg.state_reg == ADCCTL_OFF && !sample_enable;
	endproperty
	a_off_when_unpowered: assert property (p_off_when_unpowered)
		else $error("converter active while off");

	property p_wait_then_acq;
		@(posedge sys_clk) disable iff (!nrst)
		$rose(r_reg.done_flag_reg) && r_reg.control_reg[CTL_CLK_POS +: 2] == 2'b00
			&& converter_power_on |-> !sample_enable ##1 !sample_enable;
	endproperty
	a_wait_then_acq: assert property (p_wait_then_acq)
		else $error("acquisition restarted too early");

	property p_done_loads_result;
		@(posedge sys_clk) disable iff (!nrst)
		$rose(r_reg.done_flag_reg) |-> $past(r_reg.state_reg) == ADCCTL_CONV
			&& r_reg.result_reg == $past(conv_sample);
	endproperty
	a_done_loads_result: assert property (p_done_loads_result)
		else $error("done flag set without a loaded result");

	property p_start_begins_conv;
		@(posedge sys_clk) disable iff (!nrst)
		$rose(r_reg.control_reg[CTL_START_POS]) && r_reg.state_reg == ADCCTL_ACQ
			|=> r_reg.state_reg == ADCCTL_CONV;
	endproperty
	a_start_begins_conv: assert property (p_start_begins_conv)
		else $error("start bit did not begin a conversion");

	property p_all_digital;
		@(posedge sys_clk) disable iff (!nrst)
		r_reg.config_reg[3:1] == 3'h3 |-> pin_cfg.analog_en == 8'h00
			&& pin_cfg.vref_pos_sel == 2'h0 && pin_cfg.vref_neg_sel == 2'h0;
	endproperty
	a_all_digital: assert property (p_all_digital)
		else $error("all digital code left a pin analog");

	property p_small_channels;
		@(posedge sys_clk) disable iff (!nrst)
		SMALL_PACKAGE |-> pin_cfg.analog_en[7:5] == 3'h0 && input_channel_sel <= 3'h4;
	endproperty
	a_small_channels: assert property (p_small_channels)
		else $error("absent channel reachable on small package");

endmodule

// file: core/adcctl_pkg.sv
// Constants and types for the converter control block.
//
// Function
// - The clock field picks the system clock divided by 2, 8 or 32, or the converter's own RC clock for code 11.
// - The channel field sends analog input 0 to 7 to the converter.
// - With the converter powered, writing one to the start bit begins a conversion and the bit reads one until it ends.
// - Hardware clears the start bit when the conversion ends, so zero means idle.
// - The power bit switches the converter on, and clearing it shuts the converter down.
// - With the format bit set the result is right justified and the top six bits of the high byte read zero.
// - With the format bit clear the result is left justified and the low six bits of the low byte read zero.
// - Bits 6 to 4 of the configuration register always read zero.
// - The four-bit pin field decodes into analog or digital use of eight pins and the two reference sources.
// - Channels 5 to 7 do not exist on the small package, and selecting or configuring them does nothing.
// - At the end of a conversion the result is loaded, the start bit cleared and the done flag set.
// - Clearing the start bit during a conversion aborts it and leaves the result untouched.
// - After a finished or aborted conversion the block waits two bit periods before acquisition restarts.
package adcctl_pkg;

	localparam logic [7:0] ADDR_CONFIG  = 8'h9f;
	localparam logic [7:0] ADDR_CONTROL = 8'h9e;
	localparam logic [7:0] ADDR_RES_HI  = 8'h9d;
	localparam logic [7:0] ADDR_RES_LO  = 8'h9c;
	localparam logic [7:0] ADDR_STATUS  = 8'ha0;
	localparam logic [7:0] ADDR_MASK    = 8'ha1;

	localparam int CTL_CLK_POS   = 6;
	localparam int CTL_CHAN_POS  = 3;
	localparam int CTL_START_POS = 2;
	localparam int CTL_PWR_POS   = 0;
	localparam int CFG_FMT_POS   = 7;

	localparam logic [7:0] CONTROL_RESET = 8'h00;
	localparam logic [7:0] CONFIG_RESET  = 8'h00;
	localparam logic [7:0] CONFIG_MASK   = 8'h8f;

	localparam logic [5:0] DIV_FOSC2  = 6'h02;
	localparam logic [5:0] DIV_FOSC8  = 6'h08;
	localparam logic [5:0] DIV_FOSC32 = 6'h20;

	localparam logic [3:0] CONV_PERIODS = 4'hc;
	localparam logic [3:0] WAIT_PERIODS = 4'h2;

	typedef enum logic [1:0] {ADCCTL_OFF, ADCCTL_ACQ, ADCCTL_CONV, ADCCTL_WAIT} adcctl_state_t;

	typedef struct packed {
		logic       read;
		logic       write;
		logic [7:0] address;
		logic [7:0] writedata;
	} adcctl_bus_req_t;

	typedef struct packed {
		logic [7:0] readdata;
		logic       waitrequest;
	} adcctl_bus_rsp_t;

	typedef struct packed {
		logic [7:0] analog_en;
		logic [1:0] vref_pos_sel;
		logic [1:0] vref_neg_sel;
	} adcctl_pins_t;

	typedef struct packed {
		logic [7:0]    control_reg;
		logic [7:0]    config_reg;
		logic [9:0]    result_reg;
		logic          done_flag_reg;
		logic          done_mask_reg;
		adcctl_state_t state_reg;
		logic [5:0]    div_cnt_reg;
		logic [3:0]    per_cnt_reg;
		logic          tick_reg;
		logic [2:0]    rc_sync_reg;
		logic          rc_level_reg;
		logic [7:0]    readdata_reg;
		logic          ack_reg;
	} adcctl_regs_t;

endpackage

// file: bench/adcctl_analog_model.sv
// Behavioural model of the analog sample-and-convert core.
`timescale 1ns/1ps
module adcctl_analog_model (
	input  wire logic       converter_power_on,
	input  wire logic [2:0] input_channel_sel,
	output logic            rc_clk_in,
	output logic [9:0]      conv_sample
);
	logic flip;
	initial begin
		rc_clk_in = 1'b0;
		flip = 1'b0;
		forever begin
			#18.6 rc_clk_in = ~rc_clk_in;
			flip = ~flip;
		end
	end
	assign conv_sample = converter_power_on ? {input_channel_sel, 7'h2b} : {10{flip}};
endmodule

// file: bench/tb.sv
// Self-checking testbench for the converter control block.
`timescale 1ns/1ps
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin bad_count++; \
	$display("CHECK FAILED t=%0t got %h exp %h", $time, a, e); end end
module tb;
	import adcctl_pkg::*;
	logic            sys_clk;
	logic            nrst;
	adcctl_bus_req_t req;
	adcctl_bus_rsp_t rsp;
	logic            rc_clk;
	logic [9:0]      samp;
	logic            pwr;
	logic [2:0]      ch_sel;
	logic            sen;
	logic            tick;
	adcctl_pins_t    pins;
	logic            irq;
	int              bad_count = 0;
	int              n_compared = 0;
	logic [9:0]      s;
	adcctl_bus_rsp_t small_rsp;
	logic [2:0]      small_ch;
	adcctl_pins_t    small_pins;

	adcctl_top dut (.sys_clk(sys_clk), .nrst(nrst), .avs_req(req), .avs_rsp(rsp),
		.rc_clk_in(rc_clk), .conv_sample(samp), .converter_power_on(pwr),
		.input_channel_sel(ch_sel), .sample_enable(sen), .conv_bit_tick(tick),
		.pin_cfg(pins), .irq(irq));
	adcctl_analog_model model (.converter_power_on(pwr), .input_channel_sel(ch_sel),
		.rc_clk_in(rc_clk), .conv_sample(samp));
	adcctl_top #(.SMALL_PACKAGE(1'b1)) dut_small (.sys_clk(sys_clk), .nrst(nrst),
		.avs_req(req), .avs_rsp(small_rsp), .rc_clk_in(rc_clk), .conv_sample(samp),
		.converter_power_on(), .input_channel_sel(small_ch), .sample_enable(),
		.conv_bit_tick(), .pin_cfg(small_pins), .irq());

	initial begin
		sys_clk = 1'b0;
		forever #2.5 sys_clk = ~sys_clk;
	end

	task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d,
		output logic [7:0] q);
		int n;
		n = 0;
		@(posedge sys_clk);
		req.read <= ~w;
		req.write <= w;
		req.address <= a;
		req.writedata <= d;
		do begin
			@(posedge sys_clk);
			n++;
		end while (rsp.waitrequest !== 1'b0 && n < 20);
		q = rsp.readdata;
		if (n >= 20) begin
			bad_count++;
			$display("CHECK FAILED t=%0t bus request never answered", $time);
		end
		req.read <= 1'b0;
		req.write <= 1'b0;
		@(negedge sys_clk);
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		logic [7:0] q;
		bus(1'b1, a, d, q);
	endtask

	task automatic rd(input logic [7:0] a, output logic [7:0] q);
		bus(1'b0, a, 8'h00, q);
	endtask

	task automatic t_reset;
		logic [7:0] q;
		rd(ADDR_CONFIG, q);
		`CHK(q, 8'h00)
		rd(ADDR_CONTROL, q);
		`CHK(q, 8'h00)
		`CHK(pins.analog_en, 8'hff)
		`CHK({pins.vref_pos_sel, pins.vref_neg_sel}, 4'h0)
		$display("test reset done");
	endtask

	task automatic t_config;
		logic [7:0] q;
		wr(ADDR_CONFIG, 8'hff);
		rd(ADDR_CONFIG, q);
		`CHK(q, 8'h8f)
		wr(ADDR_CONFIG, 8'h06);
		`CHK(pins.analog_en, 8'h00)
		wr(ADDR_CONFIG, 8'h88);
		`CHK({pins.vref_pos_sel, pins.vref_neg_sel}, 4'h5)
		`CHK(small_pins.analog_en, 8'h13)
		wr(ADDR_CONFIG, 8'h00);
		`CHK(pins.analog_en, 8'hff)
		`CHK(small_pins.analog_en, 8'h1f)
		rd(8'h50, q);
		`CHK(q, 8'h00)
		$display("test config done");
	endtask

	task automatic t_power;
		logic [7:0] q;
		wr(ADDR_CONTROL, 8'h05);
		rd(ADDR_CONTROL, q);
		`CHK(q, 8'h01)
		`CHK(pwr, 1'b1)
		wr(ADDR_CONTROL, 8'h00);
		`CHK(pwr, 1'b0)
		$display("test power done");
	endtask

	task automatic t_conv(input logic [1:0] cs, input logic [2:0] ch);
		logic [7:0] q;
		int n;
		s = {ch, 7'h2b};
		wr(ADDR_STATUS, 8'h01);
		wr(ADDR_CONTROL, {cs, ch, 3'b001});
		`CHK(ch_sel, ch)
		`CHK(small_ch, (ch > 3'h4) ? 3'h4 : ch)
		wr(ADDR_CONTROL, {cs, ch, 3'b101});
		rd(ADDR_CONTROL, q);
		`CHK(q[2], 1'b1)
		n = 0;
		while (tick !== 1'b1 && n < 100) begin
			@(posedge sys_clk);
			#1 n++;
		end
		n = 0;
		do begin
			@(posedge sys_clk);
			#1 n++;
		end while (tick !== 1'b1 && n < 100);
		// RC edges every 7 or 8 clocks
		if (cs == 2'b11) `CHK(n == 7 || n == 8, 1'b1)
		else `CHK(n, (cs == 2'b00) ? 2 : (cs == 2'b01) ? 8 : 32)
		n = 0;
		do begin
			rd(ADDR_CONTROL, q);
			n++;
		end while (q[2] !== 1'b0 && n < 300);
		`CHK(q[2], 1'b0)
		rd(ADDR_STATUS, q);
		`CHK(q[0], 1'b1)
		rd(ADDR_RES_HI, q);
		`CHK(q, s[9:2])
		rd(ADDR_RES_LO, q);
		`CHK(q, {s[1:0], 6'h00})
		$display("test conversion %0d done", cs);
	endtask

	task automatic t_irq_fmt;
		logic [7:0] q;
		`CHK(irq, 1'b0)
		wr(ADDR_MASK, 8'h01);
		`CHK(irq, 1'b1)
		wr(ADDR_STATUS, 8'h01);
		`CHK(irq, 1'b0)
		wr(ADDR_CONFIG, 8'h80);
		rd(ADDR_RES_HI, q);
		`CHK(q, {6'h00, s[9:8]})
		rd(ADDR_RES_LO, q);
		`CHK(q, s[7:0])
		$display("test irq and format done");
	endtask

	task automatic t_abort;
		logic [7:0] q;
		wr(ADDR_CONTROL, 8'h3d);
		wr(ADDR_CONTROL, 8'h39);
		rd(ADDR_CONTROL, q);
		`CHK(q[2], 1'b0)
		repeat (100) @(posedge sys_clk);
		#1;
		`CHK(sen, 1'b1)
		rd(ADDR_STATUS, q);
		`CHK(q[0], 1'b0)
		rd(ADDR_RES_LO, q);
		`CHK(q, s[7:0])
		$display("test abort done");
	endtask

	task automatic give_verdict;
		$display("compared %0d mismatches %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	initial begin
		nrst = 1'b0;
		req = '0;
		repeat (2) @(posedge sys_clk);
		nrst <= 1'b1;
		@(posedge sys_clk);
		#1;
		t_reset();
		t_config();
		t_power();
		for (int c = 0; c < 4; c++) begin
			t_conv(c[1:0], 3'd3 + c[2:0]);
		end
		t_irq_fmt();
		t_abort();
		give_verdict();
	end

	initial begin
		#200000;
		bad_count++;
		$display("CHECK FAILED t=%0t watchdog expired", $time);
		give_verdict();
	end
endmodule
